/* design/sesc_event_ctrl.sv */
// standard event status register control and common command execution
//
// Overview of operation
// - wait command holds later commands until all earlier ones complete
// - wait command accepted without error and otherwise has no effect
// - clear-status zeroes event latches feeding status byte, and the status byte
// - clear-status over serial leaves the output queue untouched
// - clear-status over gpib keeps output queue, enable masks, message-available bit
// - enable set command loads the 8-bit mask with host value 0..255
// - enable mask is zero after power-on reset
// - enable query returns the mask as last written, 0..255
// - mask bits 7..0: power-on, user, command, exec, device, query, control, complete
// - event query returns latch then clears it; serial lacks bits 6,1,0
// - query answers carry the number only, no header
`timescale 1ns/1ps
`default_nettype none
module sesc_event_ctrl
   import sesc_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // link selection: 1 = gpib, 0 = serial
   input wire logic i_link_gpib,
   // command port from the parser
   input wire logic i_cmd_valid,
   input wire sesc_pkg::sesc_cmd_t i_cmd,
   input wire logic [WIDTH-1:0] i_cmd_arg,
   output logic o_cmd_ready,
   // completion of earlier device-specific commands
   input wire logic i_ops_pending,
   // event sources, one-cycle pulses in mask layout
   input wire logic [WIDTH-1:0] i_event_set,
   // output queue state, owned outside
   input wire logic i_output_message_available,
   // response to queries, value only
   output logic o_resp_valid,
   output logic [WIDTH-1:0] o_resp_data,
   // status
   output logic [WIDTH-1:0] o_event_enable_mask,
   output logic [WIDTH-1:0] o_standard_event_latch,
   output logic o_event_summary,
   output logic o_status_byte_clear,
   output logic o_message_available_bit
);
   // ==============================================================
   // state
   typedef enum logic [1:0] {
      SESC_ST_IDLE = 2'b01,
      SESC_ST_WAIT = 2'b10
   } sesc_state_t;

   // sequencer group: command state, answer and clear strobe
   sesc_state_t state_reg, state_next;
   logic resp_valid_reg, resp_valid_next;
   logic [WIDTH-1:0] resp_data_reg, resp_data_next;
   logic cls_reg, cls_next;
   // mask group
   logic [WIDTH-1:0] event_enable_mask_reg, event_enable_mask_next;
   // latch group
   logic [WIDTH-1:0] standard_event_latch_reg, standard_event_latch_next;
   // decode
   logic take;
   logic take_wait;
   logic take_clear;
   logic take_mask_set;
   logic take_mask_query;
   logic take_latch_query;
   logic [WIDTH-1:0] link_mask;
   logic [WIDTH-1:0] new_events;

   // ==============================================================
   // decoding helpers

   // latch bits that exist on the active link
   function automatic logic [WIDTH-1:0] sesc_link_bits(input logic gpib);
      sesc_link_bits = gpib ? WIDTH'(GPIB_LATCH_MASK) : WIDTH'(SERIAL_LATCH_MASK);
   endfunction

   // one command code taken on this edge; shared by all groups
   function automatic logic sesc_hit(
      input logic tk,
      input sesc_cmd_t cmd,
      input sesc_cmd_t code
   );
      sesc_hit = tk && (cmd == code);
   endfunction

   assign link_mask = sesc_link_bits(i_link_gpib);
   // events of bits the link lacks are dropped before the latch
   assign new_events = i_event_set & link_mask;
   // no command is taken while a wait is draining
   assign o_cmd_ready = (state_reg == SESC_ST_IDLE);
   assign take = i_cmd_valid && o_cmd_ready;

   // one strobe per command; unknown codes raise none and are dropped
   assign take_wait = sesc_hit(take, i_cmd, SESC_CMD_WAIT);
   assign take_clear = sesc_hit(take, i_cmd, SESC_CMD_CLS);
   assign take_mask_set = sesc_hit(take, i_cmd, SESC_CMD_ESE_SET);
   assign take_mask_query = sesc_hit(take, i_cmd, SESC_CMD_ESE_QRY);
   assign take_latch_query = sesc_hit(take, i_cmd, SESC_CMD_ESR_QRY);

   // ==============================================================
   // sequencer group: wait hold, query answers, clear strobe

   // wait only stalls when something is really pending
   always_comb begin
      state_next = state_reg;
      resp_valid_next = 1'b0;
      resp_data_next = resp_data_reg;
      cls_next = 1'b0;
      case (state_reg)
         SESC_ST_IDLE: begin
            // harmless when nothing is pending: no error, no side effect
            if (take_wait && i_ops_pending) begin
               state_next = SESC_ST_WAIT;
            end
            // clear strobe only; output queue is never touched here
            if (take_clear) begin
               cls_next = 1'b1;
            end
            if (take_mask_query) begin
               resp_valid_next = 1'b1;
               resp_data_next = event_enable_mask_reg;
            end
            // latch as it stood before this edge, cut to the link layout
            if (take_latch_query) begin
               resp_valid_next = 1'b1;
               resp_data_next = standard_event_latch_reg & link_mask;
            end
         end
         SESC_ST_WAIT: begin
            // ready stays low until pending is seen low
            if (!i_ops_pending) begin
               state_next = SESC_ST_IDLE;
            end
         end
         default: begin
            state_next = SESC_ST_IDLE;
         end
      endcase
   end

   // registers only; reset values are constants
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         state_reg <= SESC_ST_IDLE;
         resp_valid_reg <= 1'b0;
         resp_data_reg <= '0;
         cls_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         resp_valid_reg <= resp_valid_next;
         resp_data_reg <= resp_data_next;
         cls_reg <= cls_next;
      end
   end

   // ==============================================================
   // mask group: written only by the set command, kept by clear
   always_comb begin
      event_enable_mask_next = event_enable_mask_reg;
      // argument taken whole; not cut to the link layout, so serial keeps bits 6,1,0 too
      if (take_mask_set) begin
         event_enable_mask_next = i_cmd_arg;
      end
   end

   // power-on value; the set command with argument zero also writes zero
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         event_enable_mask_reg <= WIDTH'(MASK_RESET);
      end else begin
         event_enable_mask_reg <= event_enable_mask_next;
      end
   end

   // ==============================================================
   // latch group: sticky events, emptied by clear or by its query
   always_comb begin
      standard_event_latch_next = standard_event_latch_reg;
      if (take_clear) begin
         standard_event_latch_next = '0;
      end
      if (take_latch_query) begin
         standard_event_latch_next = '0;
      end
      // new events win over a clear in the same cycle, so none is lost
      standard_event_latch_next = standard_event_latch_next | new_events;
   end

   // reset value is a constant; the latch starts empty
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         standard_event_latch_reg <= WIDTH'(LATCH_RESET);
      end else begin
         standard_event_latch_reg <= standard_event_latch_next;
      end
   end

   // ==============================================================
   // summary and outputs
   sesc_summary #(
      .WIDTH(WIDTH)
   ) u_summary (
      .i_latch(standard_event_latch_reg),
      .i_mask(event_enable_mask_reg),
      .o_summary(o_event_summary)
   );

   // answers and strobes straight from flip-flops
   assign o_resp_valid = resp_valid_reg;
   assign o_resp_data = resp_data_reg;
   assign o_event_enable_mask = event_enable_mask_reg;
   assign o_standard_event_latch = standard_event_latch_reg;
   assign o_status_byte_clear = cls_reg;
   // message-available passes through; clear never touches it
   assign o_message_available_bit = i_output_message_available;
endmodule // sesc_event_ctrl
`default_nettype wire

/* design/sesc_pkg.sv */
// constants and types shared by the standard event status block
`default_nettype none
package sesc_pkg;
   // ==============================================================
   // command codes presented on the command port
   localparam int CMD_W = 3;
   typedef enum logic [CMD_W-1:0] {
      SESC_CMD_NONE = 3'h0,
      SESC_CMD_WAIT = 3'h1,
      SESC_CMD_CLS = 3'h2,
      SESC_CMD_ESE_SET = 3'h3,
      SESC_CMD_ESE_QRY = 3'h4,
      SESC_CMD_ESR_QRY = 3'h5
   } sesc_cmd_t;
   // ==============================================================
   // register widths and reset values
   localparam int REG_W = 8;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   // ==============================================================
   // event bit positions, shared by mask and latch
   localparam int BIT_OP_COMPLETE = 0;
   localparam int BIT_REQ_CONTROL = 1;
   localparam int BIT_QUERY_ERR = 2;
   localparam int BIT_DEVICE_ERR = 3;
   localparam int BIT_EXEC_ERR = 4;
   localparam int BIT_COMMAND_ERR = 5;
   localparam int BIT_USER_REQ = 6;
   localparam int BIT_POWER_ON = 7;
   // bits that exist on the serial link: power-on and the four errors
   localparam logic [7:0] SERIAL_LATCH_MASK = 8'hbc;
   localparam logic [7:0] GPIB_LATCH_MASK = 8'hff;
   // status byte position of output message available
   localparam int STB_MESSAGE_AVAILABLE = 4;
endpackage
`default_nettype wire

/* design/sesc_summary.sv */
// masked event summary of the standard event latch
`timescale 1ns/1ps
`default_nettype none
module sesc_summary #(
   parameter int WIDTH = 8
) (
   // operands
   input wire logic [WIDTH-1:0] i_latch,
   input wire logic [WIDTH-1:0] i_mask,
   // summary
   output logic o_summary
);
   // pure combinational, follows either register at once
   assign o_summary = |(i_latch & i_mask);
endmodule // sesc_summary
`default_nettype wire

/* bench/sesc_event_ctrl_monitor.sv */
// port checker for the event status control block
`timescale 1ns/1ps
`default_nettype none
module sesc_event_ctrl_monitor
   import sesc_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // clock, reset and link layout
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_link_gpib,
   // command port
   input wire logic i_cmd_valid,
   input wire sesc_pkg::sesc_cmd_t i_cmd,
   input wire logic [WIDTH-1:0] i_cmd_arg,
   input wire logic o_cmd_ready,
   input wire logic i_ops_pending,
   // events and answers
   input wire logic [WIDTH-1:0] i_event_set,
   input wire logic o_resp_valid,
   input wire logic [WIDTH-1:0] o_resp_data,
   // status
   input wire logic [WIDTH-1:0] o_event_enable_mask,
   input wire logic [WIDTH-1:0] o_standard_event_latch,
   input wire logic o_event_summary,
   input wire logic o_status_byte_clear
);
   // ========
   // take strobes and link layout
   wire logic tk = i_cmd_valid && o_cmd_ready;
   wire logic wai = tk && i_cmd == SESC_CMD_WAIT;
   wire logic cls = tk && i_cmd == SESC_CMD_CLS;
   wire logic mst = tk && i_cmd == SESC_CMD_ESE_SET;
   wire logic mqr = tk && i_cmd == SESC_CMD_ESE_QRY;
   wire logic rqr = tk && i_cmd == SESC_CMD_ESR_QRY;
   wire logic [WIDTH-1:0] lay = i_link_gpib ? WIDTH'(GPIB_LATCH_MASK) : WIDTH'(SERIAL_LATCH_MASK);
   wire logic [WIDTH-1:0] ev = i_event_set & lay;
   wire logic [WIDTH-1:0] lt = o_standard_event_latch & lay;
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_reset);
   AST_WAIT_HOLD: assert property (wai && i_ops_pending |=> !o_cmd_ready)
      else $error("wait not held");
   AST_WAIT_FREE: assert property (wai && !i_ops_pending |=> o_cmd_ready)
      else $error("idle wait stalled");
   AST_CLS: assert property (
      cls |=> o_status_byte_clear && o_standard_event_latch == $past(ev))
      else $error("clear failed");
   AST_CLS_ONLY: assert property (o_status_byte_clear |-> $past(cls))
      else $error("stray status clear");
   AST_CLS_KEEP: assert property (cls |=> $stable(o_event_enable_mask))
      else $error("clear hit mask");
   AST_SET: assert property (mst |=> o_event_enable_mask == $past(i_cmd_arg))
      else $error("mask not loaded");
   AST_ESE_Q: assert property (
      mqr |=> o_resp_valid && o_resp_data == $past(o_event_enable_mask))
      else $error("mask query wrong");
   AST_ESR_Q: assert property (
      rqr |=> o_resp_valid && o_resp_data == $past(lt) && o_standard_event_latch == $past(ev))
      else $error("latch query wrong");
   AST_RESP_ONLY: assert property (o_resp_valid |-> $past(mqr || rqr))
      else $error("stray answer");
   AST_SUM: assert property (
      o_event_summary == |(o_standard_event_latch & o_event_enable_mask))
      else $error("summary wrong");
   // main scenarios reached
   COV_WAIT: cover property (wai && i_ops_pending);
   COV_ESR: cover property (rqr && |o_standard_event_latch);
   COV_CLS: cover property (cls);
endmodule // sesc_event_ctrl_monitor
bind sesc_event_ctrl sesc_event_ctrl_monitor #(
   .WIDTH(WIDTH)
) mon_u (
   .i_core_clk(i_core_clk),
   .i_reset(i_reset),
   .i_link_gpib(i_link_gpib),
   .i_cmd_valid(i_cmd_valid),
   .i_cmd(i_cmd),
   .i_cmd_arg(i_cmd_arg),
   .o_cmd_ready(o_cmd_ready),
   .i_ops_pending(i_ops_pending),
   .i_event_set(i_event_set),
   .o_resp_valid(o_resp_valid),
   .o_resp_data(o_resp_data),
   .o_event_enable_mask(o_event_enable_mask),
   .o_standard_event_latch(o_standard_event_latch),
   .o_event_summary(o_event_summary),
   .o_status_byte_clear(o_status_byte_clear)
);
`default_nettype wire

/* bench/sesc_host.sv */
// host model holding each command until the block takes it
`timescale 1ns/1ps
`default_nettype none
module sesc_host
   import sesc_pkg::*;
(
   // request from the bench
   input wire logic i_core_clk,
   input wire logic i_go,
   input wire logic i_cmd_ready,
   input wire sesc_pkg::sesc_cmd_t i_req,
   input wire logic [7:0] i_arg,
   // command port
   output logic o_cmd_valid = 1'b0,
   output sesc_pkg::sesc_cmd_t o_cmd = SESC_CMD_NONE,
   output logic [7:0] o_cmd_arg = 8'h00
);
   // ========
   // after the take, scramble the argument so stale data never looks usable
   always @(posedge i_core_clk) begin
      if (i_go) begin
         o_cmd_valid <= 1'b1;
         o_cmd <= i_req;
         o_cmd_arg <= i_arg;
      end else if (o_cmd_valid && i_cmd_ready) begin
         o_cmd_valid <= 1'b0;
         o_cmd <= SESC_CMD_NONE;
         o_cmd_arg <= ~o_cmd_arg;
      end
   end
endmodule // sesc_host
`default_nettype wire

/* bench/sesc_event_ctrl_tb.sv */
// self-checking bench for the event status control block
`timescale 1ns/1ps
`default_nettype none
module sesc_event_ctrl_tb;
   import sesc_pkg::*;
   // ========
   // signals named as the ports
   logic i_core_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_link_gpib = 1'b0;
   logic go = 1'b0;
   logic i_ops_pending = 1'b0;
   logic i_output_message_available = 1'b0;
   logic i_cmd_valid, o_cmd_ready, o_resp_valid;
   logic o_event_summary, o_status_byte_clear, o_message_available_bit;
   sesc_cmd_t req = SESC_CMD_NONE, i_cmd;
   logic [7:0] arg = 8'h00, i_cmd_arg, i_event_set = 8'h00, o_resp_data, m, r, e;
   logic [7:0] o_event_enable_mask, o_standard_event_latch;
   int n_tests = 0, miscompares = 0, cyc = 0;
   always #4 i_core_clk = ~i_core_clk;
   sesc_host host_u (.i_core_clk(i_core_clk), .i_go(go), .i_cmd_ready(o_cmd_ready),
      .i_req(req), .i_arg(arg), .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd), .o_cmd_arg(i_cmd_arg));
   sesc_event_ctrl dut_u (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_link_gpib(i_link_gpib),
      .i_cmd_valid(i_cmd_valid),
      .i_cmd(i_cmd),
      .i_cmd_arg(i_cmd_arg),
      .o_cmd_ready(o_cmd_ready),
      .i_ops_pending(i_ops_pending),
      .i_event_set(i_event_set),
      .i_output_message_available(i_output_message_available),
      .o_resp_valid(o_resp_valid),
      .o_resp_data(o_resp_data),
      .o_event_enable_mask(o_event_enable_mask),
      .o_standard_event_latch(o_standard_event_latch),
      .o_event_summary(o_event_summary),
      .o_status_byte_clear(o_status_byte_clear),
      .o_message_available_bit(o_message_available_bit)
   );
   // ========
   // helpers
   // serial layout built bit by bit: power-on and the four errors only
   function automatic logic [7:0] lay(input logic g);
      logic [7:0] s;
      s = 8'h00;
      s[BIT_POWER_ON] = 1'b1;
      s[BIT_COMMAND_ERR] = 1'b1;
      s[BIT_EXEC_ERR] = 1'b1;
      s[BIT_DEVICE_ERR] = 1'b1;
      s[BIT_QUERY_ERR] = 1'b1;
      return g ? 8'hff : s;
   endfunction
   task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
      n_tests++;
      if (g !== x) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic issue(input sesc_cmd_t c, input logic [7:0] a);
      @(posedge i_core_clk);
      go <= 1'b1;
      req <= c;
      arg <= a;
      @(posedge i_core_clk);
      go <= 1'b0;
      @(negedge i_core_clk);
      while (o_cmd_ready !== 1'b1) @(negedge i_core_clk);
      @(negedge i_core_clk);
   endtask
   task automatic pulse(input logic [7:0] v, input logic g);
      @(posedge i_core_clk);
      i_event_set <= v;
      i_link_gpib <= g;
      @(posedge i_core_clk);
      i_event_set <= 8'h00;
      @(negedge i_core_clk);
   endtask
   task automatic stop_test;
      if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ========
   // cycle ceiling; also toggles the queue flag at random
   always @(posedge i_core_clk) begin
      cyc++;
      i_output_message_available <= 1'($urandom);
      if (cyc == 20000) begin
         miscompares++;
         stop_test();
      end
   end
   initial begin
      void'($urandom(34893));
      repeat (5) @(posedge i_core_clk);
      i_reset <= 1'b0;
      @(negedge i_core_clk);
      chk("mask_reset", 8'h00, o_event_enable_mask);
      for (int i = 0; i < 10; i++) begin
         m = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
         issue(SESC_CMD_ESE_SET, m);
         issue(SESC_CMD_ESE_QRY, 8'h00);
         chk("ese_query", m, o_resp_data);
         chk("resp_valid", 8'h01, {7'h0, o_resp_valid});
      end
      for (int i = 0; i < 8; i++) begin
         r = (i < 2) ? 8'hff : 8'($urandom);
         e = r & lay(i[0]);
         issue(SESC_CMD_ESE_SET, m);
         issue(SESC_CMD_ESR_QRY, 8'h00);
         pulse(r, i[0]);
         chk("latch", e, o_standard_event_latch);
         chk("summary", {7'h0, |(e & m)}, {7'h0, o_event_summary});
         issue(SESC_CMD_ESR_QRY, 8'h00);
         chk("esr_query", e, o_resp_data);
         chk("esr_clear", 8'h00, o_standard_event_latch);
         pulse(r, i[0]);
         issue(SESC_CMD_CLS, 8'h00);
         chk("cls_latch", 8'h00, o_standard_event_latch);
         chk("cls_status_byte", 8'h01, {7'h0, o_status_byte_clear});
         chk("cls_mask", m, o_event_enable_mask);
         chk("cls_msg_avail", {7'h0, i_output_message_available},
            {7'h0, o_message_available_bit});
      end
      @(posedge i_core_clk);
      i_ops_pending <= 1'b1;
      issue(SESC_CMD_WAIT, 8'h00);
      repeat (3) begin
         chk("wait_hold", 8'h00, {7'h0, o_cmd_ready});
         @(negedge i_core_clk);
      end
      @(posedge i_core_clk);
      i_ops_pending <= 1'b0;
      issue(SESC_CMD_ESE_QRY, 8'h00);
      chk("after_wait", m, o_resp_data);
      issue(SESC_CMD_WAIT, 8'h00);
      chk("wait_idle", 8'h01, {7'h0, o_cmd_ready});
      stop_test();
   end
endmodule // sesc_event_ctrl_tb
`default_nettype wire
